//--- pkg/hdlctx_defs.vh
// hdlctx_defs.vh: constants for the hdlc transmit packet processor
// assumes it is included by bare name from the rtl files
`ifndef HDLCTX_DEFS_VH
`define HDLCTX_DEFS_VH
// ==========================================================
// register indices; byte address is four times the index
`define HT_IDX_CTRL     8'hA0
`define HT_IDX_FIFO     8'hA2
`define HT_IDX_STATE    8'hA4
`define HT_IDX_LATCH    8'hA6
`define HT_IDX_MASK     8'hA8
// ==========================================================
// control fields
`define HT_C_THR_HI     12
`define HT_C_THR_LO     8
`define HT_C_PSD        6
`define HT_C_FEI        5
`define HT_C_FILL       4
`define HT_C_MSB        3
`define HT_C_INV        2
`define HT_C_FCSD       1
`define HT_C_FLUSH      0
`define HT_THR_RESET    5'h10
// ==========================================================
// status and latched status fields
`define HT_S_FREE_HI    13
`define HT_S_FREE_LO    8
`define HT_S_FULL       2
`define HT_S_EMPTY      1
`define HT_S_AVAIL      0
`define HT_L_OVF        5
`define HT_L_UNF        4
`define HT_L_PEND       3
`define HT_L_FULL       2
`define HT_L_EMPTY      1
`define HT_L_AVAIL      0
`define HT_L_W          6
// ==========================================================
// fifo, framing and timing constants
`define HT_DEPTH        9'h100
`define HT_AW           8
`define HT_FLAG         8'h7E
`define HT_ONES         8'hFF
`define HT_CRC_POLY     16'h1021
`define HT_CRC_INIT     16'hFFFF
`define HT_STUFF_RUN    3'h5
`define HT_PWRUP_NS     200
`define HT_CLK_NS       20
`define HT_PWRUP_CYC    ((`HT_PWRUP_NS + `HT_CLK_NS - 1) / `HT_CLK_NS)
`endif

//--- rtl/hdlctx_ram.v
// hdlctx_ram.v: 256 x 9 transmit fifo storage, byte plus packet-end tag
// assumes one clock; read data is registered and valid one cycle later
`timescale 1ns/1ps
`default_nettype none
`include "hdlctx_defs.vh"
module hdlctx_ram (
    input  wire             pclk,    // system clock
    input  wire             pdown,   // ram powered down, no access
    input  wire             wr_en,   // write strobe
    input  wire [`HT_AW-1:0] wr_addr, // write address
    input  wire [8:0]       wr_data, // tag in bit 8, byte below
    input  wire             rd_en,   // read strobe
    input  wire [`HT_AW-1:0] rd_addr, // read address
    output reg  [8:0]       rd_q     // registered read data
);
    reg [8:0] mem [0:`HT_DEPTH-1];

    // ==========================================================
    // storage; powered down ram neither stores nor returns data
    always @(posedge pclk) begin
        if (wr_en && !pdown) begin
            mem[wr_addr] <= wr_data;
        end
        if (pdown) begin
            rd_q <= 9'h000;
        end else if (rd_en) begin
            rd_q <= mem[rd_addr];
        end
    end
endmodule // hdlctx_ram
`default_nettype wire

//--- rtl/hdlctx_top.v
// hdlctx_top.v: hdlc transmit packet processor with apb registers
// assumes apb4 master on pclk and a framer that pulls one bit per bit_req
`timescale 1ns/1ps
`default_nettype none
`include "hdlctx_defs.vh"
module hdlctx_top (
    input  wire        pclk,     // 50 mhz clock
    input  wire        presetn,  // async reset, active low
    input  wire        psel,     // apb select
    input  wire        penable,  // apb access phase
    input  wire        pwrite,   // apb write
    input  wire [9:0]  paddr,    // apb byte address
    input  wire [31:0] pwdata,   // apb write data
    input  wire [3:0]  pstrb,    // apb byte strobes
    output wire        pready,   // apb ready, always high
    output reg  [31:0] prdata,   // apb read data, registered
    output wire        pslverr,  // unmapped address error
    input  wire        bit_req,  // framer takes one bit this cycle
    output reg         bit_out,  // serial bit toward framer
    output wire        irq       // level interrupt
);
    localparam [2:0] ST_FILL = 3'h0;
    localparam [2:0] ST_OPEN = 3'h1;
    localparam [2:0] ST_DATA = 3'h2;
    localparam [2:0] ST_FCS  = 3'h3;
    localparam [2:0] ST_CLOS = 3'h4;

    reg  [15:0] ctrl_q;
    reg  [`HT_L_W-1:0] lat_q;
    reg  [`HT_L_W-1:0] mask_q;
    reg  [8:0]  cnt_q;
    reg  [`HT_AW-1:0] wp_q;
    reg  [`HT_AW-1:0] rp_q;
    reg         pend_q;
    reg         hold_v_q;
    reg  [8:0]  hold_q;
    reg         flush_d1_q;
    reg         sync_q;
    reg  [7:0]  pwr_cnt_q;
    reg         full_d1_q;
    reg         empty_d1_q;
    reg         avail_d1_q;
    reg  [2:0]  st_q;
    reg  [7:0]  sh_q;
    reg  [3:0]  bc_q;
    reg         last_q;
    reg  [2:0]  ones_q;
    reg  [15:0] crc_q;
    wire [8:0]  ram_q;

    // ==========================================================
    // apb decode; registers sit at four times their index
    wire        setup    = psel && !penable;
    wire        access   = psel && penable;
    wire        a_ctrl   = (paddr == {`HT_IDX_CTRL, 2'b00});
    wire        a_fifo   = (paddr == {`HT_IDX_FIFO, 2'b00});
    wire        a_state  = (paddr == {`HT_IDX_STATE, 2'b00});
    wire        a_latch  = (paddr == {`HT_IDX_LATCH, 2'b00});
    wire        a_mask   = (paddr == {`HT_IDX_MASK, 2'b00});
    wire        mapped   = a_ctrl | a_fifo | a_state | a_latch | a_mask;
    wire        wr       = access && pwrite && mapped;
    assign pready  = 1'b1;
    assign pslverr = access && !mapped;

    // control fields
    wire        flush    = ctrl_q[`HT_C_FLUSH];
    wire        fcs_on   = !ctrl_q[`HT_C_FCSD];
    wire        err_ins  = ctrl_q[`HT_C_FEI] && fcs_on;
    wire [4:0]  thr      = ctrl_q[`HT_C_THR_HI:`HT_C_THR_LO];

    // ==========================================================
    // fifo level and status
    wire [8:0]  free     = `HT_DEPTH - cnt_q;
    wire        full     = (cnt_q == `HT_DEPTH);
    wire        empty    = (cnt_q == 9'h000);
    wire        avail    = (free > {1'b0, thr, 3'b000});
    wire [5:0]  groups   = free[8:3];

    // a write needs the upper lane, a live ram and room
    wire        wr_fifo  = wr && a_fifo && pstrb[1];
    wire        accept   = wr_fifo && !flush && !sync_q;
    wire        push     = accept && !full;
    wire        ovf      = accept && full;
    // one byte read ahead into the holding register
    wire        pop      = !hold_v_q && !pend_q && !empty && !flush;
    wire        flush_fall = flush_d1_q && !flush;

    hdlctx_ram u_ram (
        .pclk    (pclk),
        .pdown   (flush),
        .wr_en   (push),
        .wr_addr (wp_q),
        .wr_data ({pwdata[0], pwdata[15:8]}),
        .rd_en   (pop),
        .rd_addr (rp_q),
        .rd_q    (ram_q)
    );

    // ==========================================================
    // register writes
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= {3'h0, `HT_THR_RESET, 8'h00};
            mask_q <= {`HT_L_W{1'b0}};
        end else if (wr) begin
            if (a_ctrl && pstrb[1]) begin
                ctrl_q[15:8] <= {3'h0, pwdata[`HT_C_THR_HI:`HT_C_THR_LO]};
            end
            if (a_ctrl && pstrb[0]) begin
                ctrl_q[7:0] <= {1'b0, pwdata[6:0]};
            end
            if (a_mask && pstrb[0]) begin
                mask_q <= pwdata[`HT_L_W-1:0];
            end
        end
    end

    // read data is captured in the setup phase, so no wait states
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
        end else if (setup && !pwrite) begin
            prdata <= 32'h0000_0000;
            if (a_ctrl) begin
                prdata[15:0] <= ctrl_q;
            end
            if (a_state) begin
                prdata[`HT_S_FREE_HI:`HT_S_FREE_LO] <= groups;
                prdata[`HT_S_FULL]  <= full;
                prdata[`HT_S_EMPTY] <= empty;
                prdata[`HT_S_AVAIL] <= avail;
            end
            if (a_latch) begin
                prdata[`HT_L_W-1:0] <= lat_q;
            end
            if (a_mask) begin
                prdata[`HT_L_W-1:0] <= mask_q;
            end
        end
    end

    // ==========================================================
    // sticky events; a set in the clearing cycle wins
    wire [`HT_L_W-1:0] ev;
    wire [`HT_L_W-1:0] clr = (wr && a_latch && pstrb[0]) ? pwdata[`HT_L_W-1:0]
                                                         : {`HT_L_W{1'b0}};
    wire        unf;
    assign ev[`HT_L_OVF]   = ovf;
    assign ev[`HT_L_UNF]   = unf;
    assign ev[`HT_L_PEND]  = pend_q && ram_q[8];
    assign ev[`HT_L_FULL]  = full && !full_d1_q;
    assign ev[`HT_L_EMPTY] = (empty && !empty_d1_q) || flush_fall;
    assign ev[`HT_L_AVAIL] = (avail && !avail_d1_q) || flush_fall;
    assign irq = |(lat_q & mask_q);

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_q      <= {`HT_L_W{1'b0}};
            full_d1_q  <= 1'b0;
            empty_d1_q <= 1'b1;
            avail_d1_q <= 1'b1;
            flush_d1_q <= 1'b0;
        end else begin
            lat_q      <= (lat_q & ~clr) | ev;
            full_d1_q  <= full;
            empty_d1_q <= empty;
            avail_d1_q <= avail;
            flush_d1_q <= flush;
        end
    end

    // ==========================================================
    // fifo pointers, level and power-up wait after a flush
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q      <= {`HT_AW{1'b0}};
            rp_q      <= {`HT_AW{1'b0}};
            cnt_q     <= 9'h000;
            pend_q    <= 1'b0;
            sync_q    <= 1'b0;
            pwr_cnt_q <= 8'h00;
        end else if (flush) begin
            wp_q      <= {`HT_AW{1'b0}};
            rp_q      <= {`HT_AW{1'b0}};
            cnt_q     <= 9'h000;
            pend_q    <= 1'b0;
            sync_q    <= 1'b1;
            pwr_cnt_q <= 8'h00;
        end else begin
            if (push) begin
                wp_q <= wp_q + 1'b1;
            end
            if (pop) begin
                rp_q <= rp_q + 1'b1;
            end
            cnt_q  <= cnt_q + {8'h00, push} - {8'h00, pop};
            pend_q <= pop;
            if (sync_q) begin
                pwr_cnt_q <= pwr_cnt_q + 8'h01;
                if (pwr_cnt_q == `HT_PWRUP_CYC - 1) begin
                    sync_q <= 1'b0;
                end
            end
        end
    end

    // ==========================================================
    // serialiser; advances only when the framer takes a bit
    wire        in_pkt   = (st_q == ST_DATA) || (st_q == ST_FCS);
    wire        stuff    = (in_pkt || (st_q == ST_CLOS)) && (ones_q == `HT_STUFF_RUN);
    wire        fcs_bit  = err_ins ? crc_q[15] : !crc_q[15];
    wire        raw      = stuff ? 1'b0 : ((st_q == ST_FCS) ? fcs_bit : sh_q[0]);
    wire        byte_end = (bc_q == 4'h7);
    wire        start_ok = hold_v_q && !ctrl_q[`HT_C_PSD];
    wire [7:0]  fill     = ctrl_q[`HT_C_FILL] ? `HT_ONES : `HT_FLAG;
    // bits leave lsb first, so msb mode reverses the byte to send its msb first
    wire [7:0]  nxt_byte;
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi = gi + 1) begin : g_rev
            assign nxt_byte[gi] = ctrl_q[`HT_C_MSB] ? hold_q[7-gi] : hold_q[gi];
        end
    endgenerate
    assign unf = bit_req && !stuff && (st_q == ST_DATA) && byte_end
                 && !last_q && !hold_v_q;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q     <= ST_FILL;
            sh_q     <= `HT_FLAG;
            bc_q     <= 4'h0;
            last_q   <= 1'b0;
            ones_q   <= 3'h0;
            crc_q    <= `HT_CRC_INIT;
            hold_v_q <= 1'b0;
            hold_q   <= 9'h000;
            bit_out  <= 1'b0;
        end else if (flush) begin
            st_q     <= ST_FILL;
            sh_q     <= fill;
            bc_q     <= 4'h0;
            ones_q   <= 3'h0;
            hold_v_q <= 1'b0;
        end else begin
            if (pend_q) begin
                hold_q   <= ram_q;
                hold_v_q <= 1'b1;
            end
            if (bit_req) begin
                bit_out <= raw ^ ctrl_q[`HT_C_INV];
                if (stuff) begin
                    ones_q <= 3'h0;
                end else begin
                    ones_q <= (in_pkt && raw) ? ones_q + 3'h1 : 3'h0;
                    if (st_q == ST_DATA) begin
                        crc_q <= {crc_q[14:0], 1'b0}
                                 ^ ((crc_q[15] ^ raw) ? `HT_CRC_POLY : 16'h0000);
                    end else if (st_q == ST_FCS) begin
                        crc_q <= {crc_q[14:0], 1'b0};
                    end
                    sh_q <= {1'b0, sh_q[7:1]};
                    bc_q <= bc_q + 4'h1;
                    case (st_q)
                        ST_FILL, ST_CLOS: begin
                            if (byte_end) begin
                                bc_q <= 4'h0;
                                if (start_ok) begin
                                    st_q <= ST_OPEN;
                                    sh_q <= `HT_FLAG;
                                end else begin
                                    st_q <= ST_FILL;
                                    sh_q <= fill;
                                end
                            end
                        end
                        ST_OPEN: begin
                            if (byte_end) begin
                                bc_q  <= 4'h0;
                                crc_q <= `HT_CRC_INIT;
                                if (hold_v_q) begin
                                    st_q     <= ST_DATA;
                                    sh_q     <= nxt_byte;
                                    last_q   <= hold_q[8];
                                    hold_v_q <= 1'b0;
                                end else begin
                                    st_q <= ST_FILL;
                                    sh_q <= fill;
                                end
                            end
                        end
                        ST_DATA: begin
                            if (byte_end) begin
                                bc_q <= 4'h0;
                                if (last_q) begin
                                    st_q <= fcs_on ? ST_FCS : ST_CLOS;
                                    sh_q <= `HT_FLAG;
                                end else if (hold_v_q) begin
                                    sh_q     <= nxt_byte;
                                    last_q   <= hold_q[8];
                                    hold_v_q <= 1'b0;
                                end else begin
                                    st_q <= ST_CLOS;                 // aborts on underflow
                                    sh_q <= `HT_FLAG;
                                end
                            end
                        end
                        ST_FCS: begin
                            sh_q <= `HT_FLAG;
                            if (bc_q == 4'hF) begin
                                st_q <= ST_CLOS;
                                bc_q <= 4'h0;
                            end
                        end
                        default: begin
                            st_q <= ST_FILL;
                            sh_q <= fill;
                            bc_q <= 4'h0;
                        end
                    endcase
                end
            end
        end
    end
endmodule // hdlctx_top
`default_nettype wire

//--- dv/hdlctx_monitor.sv
// hdlctx_monitor.sv: port checker for the hdlc transmit block
// assumes the top module ports only; bound at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module hdlctx_monitor (
    input wire logic        pclk,    // clock
    input wire logic        presetn, // reset, active low
    input wire logic        psel,    // apb select
    input wire logic        penable, // apb access
    input wire logic        pwrite,  // apb write
    input wire logic [9:0]  paddr,   // apb address
    input wire logic [31:0] pwdata,  // apb write data
    input wire logic [3:0]  pstrb,   // apb strobes
    input wire logic        pready,  // apb ready
    input wire logic [31:0] prdata,  // apb read data
    input wire logic        pslverr, // apb error
    input wire logic        bit_req, // framer pull
    input wire logic        bit_out, // serial bit
    input wire logic        irq      // interrupt
);
    // ==========================================================
    // shadow state
    logic [15:0] ctrl_q;  // control as software last wrote it
    logic        msk_q;   // a mask bit was ever written high
    wire         acc = psel && penable;
    wire         rds = psel && !penable && !pwrite;
    wire         hit = paddr inside {10'h280, 10'h288, 10'h290, 10'h298, 10'h2A0};
    wire  [5:0]  thr = {1'b0, ctrl_q[12:8]};
    // shadow follows committed writes only, byte by byte
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= 16'h1000;
            msk_q  <= 1'b0;
        end else if (acc && pwrite) begin
            if (paddr == 10'h280 && pstrb[0]) ctrl_q[7:0] <= pwdata[7:0] & 8'h7F;
            if (paddr == 10'h280 && pstrb[1]) ctrl_q[15:8] <= pwdata[15:8] & 8'h1F;
            if (paddr == 10'h2A0 && pwdata[5:0] != 6'h00) msk_q <= 1'b1;
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    AST_READY: assert property (pready) else $error("pready low");
    AST_MAPPED_OK: assert property (acc && hit |-> !pslverr) else $error("error on map");
    AST_UNMAPPED_ERR: assert property (acc && !hit |-> pslverr) else $error("no error");
    AST_UNMAPPED_RD: assert property (rds && !hit |=> prdata == 32'h0)
        else $error("unmapped read data");
    AST_FIFO_RD: assert property (rds && paddr == 10'h288 |=> prdata == 32'h0)
        else $error("fifo read data");
    AST_CTRL_RD: assert property (rds && paddr == 10'h280 |=> prdata == {16'h0, ctrl_q})
        else $error("control readback");
    AST_AVAIL: assert property (rds && paddr == 10'h290 |=>
        (prdata[13:8] <= thr || prdata[0]) && (prdata[13:8] >= thr || !prdata[0]))
        else $error("space flag versus level");
    AST_FULL: assert property (rds && paddr == 10'h290 |=>
        (!prdata[2] || prdata[13:8] == 6'h0) && (!prdata[1] || prdata[13:8] == 6'h20))
        else $error("full or empty versus level");
    AST_BIT_HOLD: assert property (!bit_req |=> $stable(bit_out)) else $error("bit moved");
    AST_IRQ_QUIET: assert property (!msk_q |-> !irq) else $error("irq while masked");
    cover property (acc && pwrite && paddr == 10'h288 && pwdata[0]);
    cover property ($rose(irq));
    cover property (rds && paddr == 10'h290 ##1 prdata[2]);
endmodule // hdlctx_monitor
bind hdlctx_top hdlctx_monitor hdlctx_monitor_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready), .prdata(prdata),
    .pslverr(pslverr), .bit_req(bit_req), .bit_out(bit_out), .irq(irq));
`default_nettype wire

//--- dv/hdlctx_framer_model.sv
// hdlctx_framer_model.sv: framer side that pulls serial bits
// assumes bit_out is valid after the edge that saw bit_req high
`timescale 1ns/1ps
`default_nettype none
module hdlctx_framer_model #(
    parameter int GAP = 2 // cycles between pulls, one at the fastest
) (
    input  wire logic pclk,    // clock
    input  wire logic presetn, // reset, active low
    input  wire logic bit_out, // serial bit from the block
    output var  logic bit_req  // one-cycle pull
);
    // ==========================================================
    // pull pacing and capture; wider gaps model a slow framer
    logic got_q[$]; // every bit taken, oldest first
    int   cnt_q;    // cycles since last pull
    logic take_q;   // the pulled bit is settled now
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q   <= 0;
            bit_req <= 1'b0;
            take_q  <= 1'b0;
        end else begin
            take_q  <= bit_req;
            if (take_q) got_q.push_back(bit_out);
            bit_req <= (cnt_q == GAP - 1);
            cnt_q   <= (cnt_q == GAP - 1) ? 0 : cnt_q + 1;
        end
    end
endmodule // hdlctx_framer_model
`default_nettype wire

//--- dv/tb_hdlc_transmit_packet_processor.sv
// tb_hdlc_transmit_packet_processor.sv: self-checking bench for the block
// assumes zero-wait apb and the framer model pulling every other cycle
`timescale 1ns/1ps
`default_nettype none
module tb_hdlc_transmit_packet_processor;
    localparam logic [9:0] A_CTRL = 10'h280, A_FIFO = 10'h288, A_STATE = 10'h290;
    localparam logic [9:0] A_LATCH = 10'h298, A_MASK = 10'h2A0;
    logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [9:0]  paddr = 10'h0;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'h0;
    wire  logic  pready, pslverr, bit_req, bit_out, irq;
    wire  logic [31:0] prdata;
    int          fail_count = 0, tests_run = 0;
    logic        exp_q[$];  // expected serial bits of one frame
    logic [7:0]  pkt[3] = '{8'hFF, 8'h3C, 8'h81}; // ones run forces stuffing
    logic [7:0]  cfg[4] = '{8'h00, 8'h28, 8'h26, 8'h0C};
    hdlctx_top hdlctx_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb),
        .pready(pready), .prdata(prdata), .pslverr(pslverr), .bit_req(bit_req),
        .bit_out(bit_out), .irq(irq));
    hdlctx_framer_model #(.GAP(2)) hdlctx_framer_model_inst (.pclk(pclk),
        .presetn(presetn), .bit_out(bit_out), .bit_req(bit_req));
    always #10 pclk = ~pclk;
    // ==========================================================
    // shared tasks
    task automatic wrap_up();
        if (fail_count == 0 && tests_run > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one apb transfer; ends off the edge so outputs have settled
    task automatic xfer(input logic w, input logic [9:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        @(posedge pclk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hF;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (n >= 50) begin
            fail_count++;
            wrap_up();
        end
        @(negedge pclk);
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        logic [31:0] q;
        xfer(1'b1, a, d, q);
    endtask
    task automatic rd(input logic [9:0] a, output logic [31:0] q);
        xfer(1'b0, a, 32'h0, q);
    endtask
    task automatic put_flag(input logic inv);
        for (int i = 0; i < 8; i++) exp_q.push_back(inv ^ (i != 0 && i != 7));
    endtask
    // expected frame for the control low byte c
    task automatic build(input logic [7:0] c);
        logic [15:0] crc;
        logic        d[$];
        logic        x;
        int          run;
        crc = 16'hFFFF;
        for (int i = 0; i < 24; i++) begin
            x = c[3] ? pkt[i/8][7-i%8] : pkt[i/8][i%8];
            d.push_back(x);
            crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ x) ? 16'h1021 : 16'h0);
        end
        for (int k = 15; k >= 0 && !c[1]; k--) d.push_back(crc[k] ^ !c[5]);
        exp_q.delete();
        put_flag(c[2]);
        run = 0;
        foreach (d[i]) begin
            exp_q.push_back(d[i] ^ c[2]);
            run = d[i] ? run + 1 : 0;
            if (run == 5) begin
                exp_q.push_back(c[2]);
                run = 0;
            end
        end
        put_flag(c[2]);
    endtask
    function automatic logic found();
        int k;
        for (int s = 0; s + exp_q.size() <= hdlctx_framer_model_inst.got_q.size(); s++) begin
            for (k = 0; k < exp_q.size(); k++)
                if (hdlctx_framer_model_inst.got_q[s+k] !== exp_q[k]) break;
            if (k == exp_q.size()) return 1'b1;
        end
        return 1'b0;
    endfunction
    task automatic send_pkt();
        for (int i = 0; i < 3; i++) wr(A_FIFO, {16'h0, pkt[i], 7'h0, i == 2});
    endtask
    // ==========================================================
    // scenarios
    task automatic t_regs();
        logic [9:0]  ad[6] = '{A_CTRL, A_STATE, A_MASK, A_LATCH, A_FIFO, 10'h2AC};
        logic [31:0] ev[6] = '{32'h1000, 32'h2003, 32'h0, 32'h0, 32'h0, 32'h0};
        logic [31:0] q;
        foreach (ad[i]) begin
            rd(ad[i], q);
            chk("reset value", q, ev[i]);
        end
    endtask
    task automatic t_fill();
        logic z;
        wr(A_CTRL, 32'h1010);
        repeat (40) @(posedge pclk);
        hdlctx_framer_model_inst.got_q.delete();
        repeat (100) @(posedge pclk);
        z = 1'b0;
        foreach (hdlctx_framer_model_inst.got_q[i]) z |= (hdlctx_framer_model_inst.got_q[i] !== 1'b1);
        chk("ones fill", z, 0);
        wr(A_CTRL, 32'h1000);
        hdlctx_framer_model_inst.got_q.delete();
        repeat (100) @(posedge pclk);
        exp_q.delete();
        put_flag(1'b0);
        put_flag(1'b0);
        chk("flag fill", found(), 1);
    endtask
    task automatic t_frame(input logic [7:0] c);
        logic [31:0] q;
        wr(A_CTRL, {24'h10, c});
        hdlctx_framer_model_inst.got_q.delete();
        send_pkt();
        repeat (600) @(posedge pclk);
        build(c);
        chk("frame", found(), 1);
        rd(A_LATCH, q);
        chk("packet end latched", q[3], 1);
        chk("irq raised", irq, 1);
        wr(A_MASK, 32'h0);
        chk("irq masked", irq, 0);
        wr(A_MASK, 32'h8);
        wr(A_LATCH, 32'h3F);
        chk("irq cleared", irq, 0);
    endtask
    task automatic t_psd();
        logic [31:0] q;
        wr(A_CTRL, 32'h1040);
        send_pkt();
        repeat (600) @(posedge pclk);
        rd(A_STATE, q);
        chk("held packet", q[1], 0);
        wr(A_CTRL, 32'h1000);
        repeat (600) @(posedge pclk);
        rd(A_STATE, q);
        chk("released packet", q[1], 1);
    endtask
    task automatic t_flush();
        logic [31:0] q;
        wr(A_CTRL, 32'h1040);
        repeat (2) wr(A_FIFO, 32'h5500);
        wr(A_CTRL, 32'h1041);
        rd(A_STATE, q);
        chk("flushed", q[1], 1);
        wr(A_FIFO, 32'h5500);
        rd(A_STATE, q);
        chk("write in flush", q[1], 1);
        wr(A_CTRL, 32'h1040);
        repeat (2) wr(A_FIFO, 32'h5500);
        rd(A_STATE, q);
        chk("write in power up", q[1], 1);
        rd(A_LATCH, q);
        chk("flush release latch", q[1:0], 2'h3);
        repeat (20) @(posedge pclk);
        repeat (2) wr(A_FIFO, 32'h5500);
        rd(A_STATE, q);
        chk("write after power up", q[1], 0);
    endtask
    task automatic t_full();
        logic [31:0] q;
        wr(A_CTRL, 32'h0241);
        wr(A_CTRL, 32'h0240);
        repeat (20) @(posedge pclk);
        for (int n = 1; n <= 258; n++) begin
            wr(A_FIFO, {16'h0, n[7:0], 8'h0});
            if (n == 240 || n == 241 || n == 256 || n == 257) begin
                rd(A_STATE, q);
                case (n)
                    240: chk("state free 17", q, 32'h0201);
                    241: chk("state free 16", q, 32'h0200);
                    256: chk("state free 1", q, 32'h0000);
                    default: chk("state full", q, 32'h0004);
                endcase
            end
        end
        rd(A_LATCH, q);
        chk("overflow latched", q[5], 1);
    endtask
    // ==========================================================
    // main sequence and watchdog
    initial begin
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_fill();
        wr(A_MASK, 32'h8);
        foreach (cfg[i]) t_frame(cfg[i]);
        t_psd();
        t_flush();
        t_full();
        wrap_up();
    end
    initial begin
        repeat (100000) @(posedge pclk);
        fail_count++;
        wrap_up();
    end
endmodule // tb_hdlc_transmit_packet_processor
`default_nettype wire
